// *** design/css_top.sv ***
// css_top.sv: processor core system signals behind an apb register file
// assumes: pclk at 100 MHz, presetn async active low, every pin input async
`timescale 1ns/1ps
`include "css_map.svh"
module css_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // transfer request and attributes
   output logic xfer_req_n,
   output logic xfer_busy_n,
   output logic xfer_abort_n,
   output logic [31:0] xfer_addr,
   output logic xfer_read,
   output logic [1:0] xfer_size,
   output logic data_as_next_addr,
   output logic sequential_hint_n,
   // data bus, split three ways
   input wire logic [31:0] data_in,
   output logic [31:0] data_out,
   output logic data_oe,
   // transfer termination
   input wire logic xfer_ack_n,
   input wire logic xfer_err_n,
   input wire logic brk_req_n,
   // translate control and soft reset
   output logic translate_ctl_n,
   input wire logic soft_rst_n,
   // interrupts
   input wire logic irq_n,
   input wire logic fast_irq_n,
   input wire logic auto_vector_n,
   input wire logic [6:0] irq_vector_num,
   output logic irq_pending_n,
   // power, status, global buses, debug
   output logic [1:0] low_power_mode_n,
   output logic [3:0] core_status_code,
   output logic [31:0] global_ctl_out,
   input wire logic [31:0] global_stat_in,
   input wire logic debug_req_n,
   output logic debug_ack_n
);
   import css_pkg::*;

   localparam int SYNC_W = 79;

   // every pin input passes two flops; active-low pins rest high in reset
   logic [SYNC_W-1:0] pins_s;
   css_sync #(
      .W(SYNC_W),
      .RST_VAL({8'hFF, 71'h0})
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({xfer_ack_n, xfer_err_n, brk_req_n, irq_n, fast_irq_n, auto_vector_n,
         soft_rst_n, debug_req_n, irq_vector_num, data_in, global_stat_in}),
      .q(pins_s)
   );

   // synchronised pins turned active high
   wire ack_s = ~pins_s[78];
   wire err_s = ~pins_s[77];
   wire brk_s = ~pins_s[76];
   wire irq_s = ~pins_s[75];
   wire fast_s = ~pins_s[74];
   wire auto_s = ~pins_s[73];
   wire sreset_s = ~pins_s[72];
   wire dbg_s = ~pins_s[71];
   wire [6:0] vec_s = pins_s[70:64];
   wire [31:0] din_s = pins_s[63:32];
   wire [31:0] gstat_s = pins_s[31:0];

   // software-visible state
   logic [2:0] ctrl;
   logic [31:0] addr_reg;
   logic [31:0] wdata_reg;
   logic [31:0] rdata_reg;
   logic [31:0] gstat_reg;
   css_launch_t launch;
   logic [4:0] st;
   logic [1:0] lpm;
   logic [3:0] psc_sw;
   logic psc_pulse;
   logic dbg_mode;
   logic exc_pulse;
   logic sreset_d;
   logic [7:0] exc_vec;
   logic [31:0] rd_mux;
   logic [3:0] next_psc;
   css_xfer_state_t state, next_state;
   // interrupt carrier, declared ahead of the read mux that looks into it
   css_irq_if irq_bus();

   // address match used by every register select
   function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
      hit = (a == {24'h0, ofs});
   endfunction

   // apb phases and register selects
   wire apb_wr = psel & penable & pwrite;
   wire apb_setup = psel & ~penable;
   wire h_ctrl = hit(paddr, `CSS_OFS_CTRL);
   wire h_addr = hit(paddr, `CSS_OFS_ADDR);
   wire h_wdata = hit(paddr, `CSS_OFS_WDATA);
   wire h_launch = hit(paddr, `CSS_OFS_LAUNCH);
   wire h_xstat = hit(paddr, `CSS_OFS_XSTAT);
   wire h_rdata = hit(paddr, `CSS_OFS_RDATA);
   wire h_irq = hit(paddr, `CSS_OFS_IRQ);
   wire h_lpm = hit(paddr, `CSS_OFS_LPM);
   wire h_psc = hit(paddr, `CSS_OFS_PSC);
   wire h_debug = hit(paddr, `CSS_OFS_DEBUG);
   wire h_gctl = hit(paddr, `CSS_OFS_GCTL);
   wire h_gstat = hit(paddr, `CSS_OFS_GSTAT);
   wire h_exc = hit(paddr, `CSS_OFS_EXC);
   wire mapped = h_ctrl | h_addr | h_wdata | h_launch | h_xstat | h_rdata | h_irq |
      h_lpm | h_psc | h_debug | h_gctl | h_gstat | h_exc;

   // zero-wait slave; prdata is loaded in the setup phase so it comes from a flop
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // launch and transfer conditions
   wire size_bad = (pwdata[`CSS_LN_SIZE] == `CSS_SIZE_RSVD);
   wire launch_wr = apb_wr & h_launch & pwdata[`CSS_LN_GO];
   wire launch_ok = launch_wr & (state == XS_IDLE) & ~size_bad;
   wire in_access = (state == XS_WAIT) | (state == XS_ABORT);
   wire term_hit = (state == XS_WAIT) & (ack_s | err_s);
   wire xfer_ok = term_hit & ack_s & ~err_s;
   wire xfer_bad = term_hit & err_s;
   wire brk_take = term_hit & brk_s & (~launch.instr | ~launch.discard);

   // soft reset is edge-triggered: one exception per assertion
   wire sreset_edge = sreset_s & ~sreset_d;

   // read selection
   always_comb begin
      rd_mux = 32'h0;
      if (h_ctrl)
         rd_mux = {29'h0, ctrl};
      else if (h_addr)
         rd_mux = addr_reg;
      else if (h_wdata)
         rd_mux = wdata_reg;
      else if (h_launch)
         rd_mux = {23'h0, launch, 1'b0};
      else if (h_xstat)
         rd_mux = {26'h0, in_access, st};
      else if (h_rdata)
         rd_mux = rdata_reg;
      else if (h_irq)
         rd_mux = {17'h0, irq_bus.vec_num, 6'h0, irq_bus.is_fast, irq_bus.pending};
      else if (h_lpm)
         rd_mux = {30'h0, lpm};
      else if (h_psc)
         rd_mux = {28'h0, core_status_code};
      else if (h_debug)
         rd_mux = {31'h0, dbg_mode};
      else if (h_gctl)
         rd_mux = global_ctl_out;
      else if (h_gstat)
         rd_mux = gstat_reg;
      else if (h_exc)
         rd_mux = {24'h0, exc_vec};
   end

   // read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `CSS_WORD_RST;
      end else if (apb_setup) begin
         prdata <= rd_mux;
      end
   end

   // control, address, write data and global control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CSS_CTRL_RST;
         addr_reg <= `CSS_WORD_RST;
         wdata_reg <= `CSS_WORD_RST;
         global_ctl_out <= `CSS_WORD_RST;
      end else if (apb_wr) begin
         if (h_ctrl)
            ctrl <= pwdata[2:0];
         if (h_addr)
            addr_reg <= pwdata;
         if (h_wdata)
            wdata_reg <= pwdata;
         if (h_gctl)
            global_ctl_out <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gstat_reg <= `CSS_WORD_RST;
      end else begin
         gstat_reg <= gstat_s;
      end
   end

   assign translate_ctl_n = ~ctrl[`CSS_CTRL_XLATE];

   // transfer sequencer: one request, optional abort, then wait for termination
   always_comb begin
      next_state = state;
      case (state)
         XS_IDLE: begin
            if (launch_ok)
               next_state = XS_REQ;
         end
         XS_REQ: begin
            if (launch.abort)
               next_state = XS_ABORT;
            else
               next_state = XS_WAIT;
         end
         XS_ABORT: begin
            next_state = XS_WAIT;
         end
         default: begin
            if (term_hit)
               next_state = XS_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= XS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign xfer_req_n = ~(state == XS_REQ);
   assign xfer_busy_n = ~in_access;
   assign xfer_abort_n = ~(state == XS_ABORT);
   assign sequential_hint_n = 1'b1;
   // drive data only on a write that was not aborted
   assign data_oe = (state == XS_WAIT) & ~xfer_read & ~launch.abort;

   // attributes latched at launch so they stand through the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         launch <= '0;
         xfer_addr <= `CSS_WORD_RST;
         xfer_read <= 1'b1;
         xfer_size <= 2'h0;
         data_as_next_addr <= 1'b0;
         data_out <= `CSS_WORD_RST;
      end else if (launch_ok) begin
         launch <= css_launch_t'(pwdata[`CSS_LN_FIELDS]);
         xfer_addr <= pwdata[8] ? rdata_reg : addr_reg;
         xfer_read <= pwdata[1];
         xfer_size <= pwdata[`CSS_LN_SIZE];
         data_as_next_addr <= pwdata[4];
         data_out <= wdata_reg;
      end
   end

   // read data kept only from a successful, not aborted read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= `CSS_WORD_RST;
      end else if (xfer_ok & xfer_read & ~launch.abort) begin
         rdata_reg <= din_s;
      end
   end

   // sticky status: done, error, breakpoint, refused size, soft reset
   // write-one-to-clear; a set in the same cycle wins over the clear
   wire [4:0] st_set = {sreset_edge, launch_wr & size_bad, brk_take, xfer_bad, term_hit};
   wire [4:0] st_clr = (apb_wr & h_xstat) ? pwdata[4:0] : 5'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= 5'h0;
      end else begin
         st <= (st & ~st_clr) | st_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sreset_d <= 1'b0;
         exc_pulse <= 1'b0;
         exc_vec <= 8'h0;
      end else begin
         sreset_d <= sreset_s;
         exc_pulse <= sreset_edge;
         if (sreset_edge)
            exc_vec <= `CSS_VEC_SOFT;
      end
   end

   // interrupt recogniser behind its carrier
   // active-low levels inverted
   assign irq_bus.irq_req = irq_s;
   assign irq_bus.fast_req = fast_s;
   assign irq_bus.auto_vec = auto_s;
   assign irq_bus.vec_in = vec_s;
   assign irq_bus.ie = ctrl[`CSS_CTRL_IE];
   assign irq_bus.fe = ctrl[`CSS_CTRL_FE];
   css_irq u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .ir(irq_bus.ctrl)
   );
   assign irq_pending_n = ~irq_bus.pending;

   // low-power mode: a write of stop, wait or doze enters it; normal is ignored
   wire lp_active = (lpm != `CSS_LPM_NORMAL);
   wire lpm_wr = apb_wr & h_lpm & (pwdata[1:0] != `CSS_LPM_NORMAL);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lpm <= `CSS_LPM_NORMAL;
      end else if (lp_active & (irq_bus.pending | dbg_s)) begin
         lpm <= `CSS_LPM_NORMAL;
      end else if (lpm_wr & ~lp_active) begin
         lpm <= pwdata[1:0];
      end
   end
   assign low_power_mode_n = lpm;

   // debug mode: request enters it, software exit leaves only without request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_mode <= 1'b0;
      end else if (dbg_s) begin
         dbg_mode <= 1'b1;
      end else if (apb_wr & h_debug & pwdata[0]) begin
         dbg_mode <= 1'b0;
      end
   end
   assign debug_ack_n = ~dbg_mode;

   // software launch codes last one cycle; reserved codes are dropped
   wire psc_rsvd = (pwdata[3:0] == 4'h3) | (pwdata[3:0] == 4'h7) |
      (pwdata[3:0] == 4'hE);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psc_sw <= `CSS_PSC_STALL;
         psc_pulse <= 1'b0;
      end else begin
         psc_pulse <= apb_wr & h_psc & ~psc_rsvd;
         if (apb_wr & h_psc & ~psc_rsvd)
            psc_sw <= pwdata[3:0];
      end
   end

   always_comb begin
      next_psc = `CSS_PSC_STALL;
      if (dbg_mode)
         next_psc = `CSS_PSC_DBG;
      else if (lp_active)
         next_psc = `CSS_PSC_LP;
      else if (exc_pulse)
         next_psc = `CSS_PSC_EXC;
      else if (psc_pulse)
         next_psc = psc_sw;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_status_code <= `CSS_PSC_STALL;
      end else begin
         core_status_code <= next_psc;
      end
   end
endmodule

// *** design/css_map.svh ***
// css_map.svh: register offsets, field positions, encodings and reset values
// assumes: included by its bare name; definitions only
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
// register offsets (byte addresses, one word each)
`define CSS_OFS_CTRL 8'h00
`define CSS_OFS_ADDR 8'h04
`define CSS_OFS_WDATA 8'h08
`define CSS_OFS_LAUNCH 8'h0C
`define CSS_OFS_XSTAT 8'h10
`define CSS_OFS_RDATA 8'h14
`define CSS_OFS_IRQ 8'h18
`define CSS_OFS_LPM 8'h1C
`define CSS_OFS_PSC 8'h20
`define CSS_OFS_DEBUG 8'h24
`define CSS_OFS_GCTL 8'h28
`define CSS_OFS_GSTAT 8'h2C
`define CSS_OFS_EXC 8'h30
// control register fields
`define CSS_CTRL_XLATE 0
`define CSS_CTRL_IE 1
`define CSS_CTRL_FE 2
// launch register: go bit, then the packed launch fields
`define CSS_LN_GO 0
`define CSS_LN_FIELDS 8:1
`define CSS_LN_SIZE 3:2
// encodings
`define CSS_SIZE_RSVD 2'h3
`define CSS_LPM_NORMAL 2'h3
`define CSS_PSC_STALL 4'h0
`define CSS_PSC_EXC 4'h2
`define CSS_PSC_LP 4'h4
`define CSS_PSC_DBG 4'h6
`define CSS_VEC_SOFT 8'h24
`define CSS_AUTO_NORMAL 7'h18
`define CSS_AUTO_FAST 7'h1C
// reset values
`define CSS_CTRL_RST 3'h0
`define CSS_WORD_RST 32'h0
`endif

// *** design/css_pkg.sv ***
// css_pkg.sv: types shared by the core system-signal block
// assumes: compiled before every other design file
package css_pkg;
   // transfer sequencer states, gray along idle-req-wait; wait back to idle flips both bits
   typedef enum logic [1:0] {
      XS_IDLE = 2'h0,
      XS_REQ = 2'h1,
      XS_WAIT = 2'h3,
      XS_ABORT = 2'h2
   } css_xfer_state_t;
   // launch fields as written to the launch register, bits 8..1
   typedef struct packed {
      logic addr_from_data;
      logic abort;
      logic discard;
      logic instr;
      logic addr_hint;
      logic [1:0] size;
      logic rd;
   } css_launch_t;
endpackage

// *** design/css_irq_if.sv ***
// css_irq_if.sv: carrier between the top and the interrupt recogniser
// assumes: one instance inside css_top
`timescale 1ns/1ps
interface css_irq_if;
   logic irq_req;
   logic fast_req;
   logic auto_vec;
   logic [6:0] vec_in;
   logic ie;
   logic fe;
   logic pending;
   logic is_fast;
   logic [6:0] vec_num;
   modport core (output irq_req, fast_req, auto_vec, vec_in, ie, fe,
      input pending, is_fast, vec_num);
   modport ctrl (input irq_req, fast_req, auto_vec, vec_in, ie, fe,
      output pending, is_fast, vec_num);
endinterface

// *** design/css_sync.sv ***
// css_sync.sv: two-flop synchroniser for a vector of pin inputs
// assumes: each bit is an independent level; RST_VAL is a constant
`timescale 1ns/1ps
module css_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pins in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// *** design/css_irq.sv ***
// css_irq.sv: interrupt recogniser with vector selection
// assumes: request levels arrive synchronised and active-high
`timescale 1ns/1ps
`include "css_map.svh"
module css_irq (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // requests in, pending and vector out
   css_irq_if.ctrl ir
);
   import css_pkg::*;
   // a request counts only while its enable allows it
   wire norm_ok = ir.irq_req & ir.ie;
   wire fast_ok = ir.fast_req & ir.fe;
   wire [6:0] norm_vec = ir.auto_vec ? `CSS_AUTO_NORMAL : ir.vec_in;
   wire [6:0] fast_vec = ir.auto_vec ? `CSS_AUTO_FAST : ir.vec_in;
   // level requests pending; fast wins over normal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir.pending <= 1'b0;
         ir.is_fast <= 1'b0;
         ir.vec_num <= 7'h0;
      end else begin
         ir.pending <= norm_ok | fast_ok;
         if (fast_ok) begin
            ir.is_fast <= 1'b1;
            ir.vec_num <= fast_vec;
         end else if (norm_ok) begin
            ir.is_fast <= 1'b0;
            ir.vec_num <= norm_vec;
         end
      end
   end
endmodule

// *** tb/css_chk.sv ***
// css_chk.sv: port-level checker for the core system-signal block
// assumes: bound to css_top; one clock domain, reset async active low
`timescale 1ns/1ps
module css_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   // transfer request and attributes
   input wire logic xfer_req_n,
   input wire logic xfer_busy_n,
   input wire logic xfer_abort_n,
   input wire logic [31:0] xfer_addr,
   input wire logic xfer_read,
   input wire logic [1:0] xfer_size,
   input wire logic sequential_hint_n,
   // control, power, status, debug
   input wire logic translate_ctl_n,
   input wire logic [1:0] low_power_mode_n,
   input wire logic [3:0] core_status_code,
   input wire logic [31:0] global_ctl_out,
   input wire logic debug_ack_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   // apb write completing this cycle
   assign wr = psel && penable && pwrite;
   a_req_pulse: assert property ($fell(xfer_req_n) |=> xfer_req_n)
      else $error("request held longer than one cycle");
   a_req_busy: assert property (!xfer_req_n && xfer_busy_n |=> !xfer_busy_n)
      else $error("accepted request without busy");
   a_abort_slot: assert property (!xfer_abort_n |-> $past(!xfer_req_n) ##1 xfer_abort_n)
      else $error("abort outside the slot after a request");
   a_attr_hold: assert property (!xfer_busy_n |-> $stable({xfer_addr, xfer_read, xfer_size}))
      else $error("attributes moved during an access");
   a_size_legal: assert property (xfer_size != 2'h3)
      else $error("reserved size issued");
   a_hint_negated: assert property (sequential_hint_n)
      else $error("sequential hint asserted");
   a_xlate_source: assert property ($changed(translate_ctl_n)
      |-> $past(wr && paddr == 32'h0))
      else $error("translate control moved without control write");
   a_gctl_source: assert property ($changed(global_ctl_out)
      |-> $past(wr && paddr == 32'h28))
      else $error("global control moved without register write");
   a_lpm_entry: assert property (low_power_mode_n != 2'h3 && $past(low_power_mode_n) == 2'h3
      |-> $past(wr && paddr == 32'h1C))
      else $error("low power entered without mode write");
   a_status_rsvd: assert property (!(core_status_code inside {4'h3, 4'h7, 4'hE}))
      else $error("reserved status code shown");
   a_dbg_status: assert property (!debug_ack_n && $past(!debug_ack_n) |-> core_status_code == 4'h6)
      else $error("debug mode without debug status");
   c_abort: cover property (!xfer_abort_n);
   c_stop: cover property (low_power_mode_n == 2'h0);
   c_debug: cover property (!debug_ack_n && core_status_code == 4'h6);
endmodule
bind css_top css_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .xfer_req_n,
   .xfer_busy_n, .xfer_abort_n, .xfer_addr, .xfer_read, .xfer_size, .sequential_hint_n,
   .translate_ctl_n, .low_power_mode_n, .core_status_code, .global_ctl_out, .debug_ack_n);

// *** tb/css_slave.sv ***
// css_slave.sv: bus slave model answering the core's transfer requests
// assumes: one access at a time; the bench sets the mode inputs before a launch
`timescale 1ns/1ps
module css_slave (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // requests from the core
   input wire logic xfer_req_n,
   input wire logic xfer_abort_n,
   input wire logic xfer_read,
   // behaviour chosen by the bench
   input wire logic err_mode,
   input wire logic brk_mode,
   input wire logic [3:0] dly,
   input wire logic [31:0] rdata,
   // termination and read data
   output logic xfer_ack_n,
   output logic xfer_err_n,
   output logic brk_req_n,
   output logic [31:0] data_in
);
   logic [4:0] cnt;
   logic act;
   logic hit;
   logic rd_l;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 5'h0;
         act <= 1'b0;
         rd_l <= 1'b0;
      end else begin
         act <= !xfer_req_n ? 1'b0 : (cnt == 5'h1 && xfer_abort_n);
         if (!xfer_req_n) begin
            cnt <= {1'b0, dly} + 5'h1;
            rd_l <= xfer_read;
         end else if (!xfer_abort_n) begin
            cnt <= 5'h0;
         end else if (cnt != 5'h0) begin
            cnt <= cnt - 5'h1;
         end
      end
   end
   // end an aborted access in the abort cycle itself
   assign hit = act | ~xfer_abort_n;
   assign xfer_ack_n = ~(hit & ~err_mode);
   assign xfer_err_n = ~(hit & err_mode);
   // breakpoint held low outside termination, where it must be ignored
   assign brk_req_n = hit ? ~brk_mode : 1'b0;
   // data valid only in the termination cycle; inverse otherwise
   assign data_in = (act & rd_l) ? rdata : ~rdata;
endmodule

// *** tb/tb_top.sv ***
// tb_top.sv: self-checking bench for css_top
// assumes: css_slave answers transfers; the checker is bound separately
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, soft_rst_n, irq_n, fast_irq_n, auto_vector_n;
   logic debug_req_n, err_mode, brk_mode, pready, pslverr, xfer_req_n, xfer_busy_n;
   logic xfer_abort_n, xfer_read, data_as_next_addr, sequential_hint_n, data_oe, xfer_ack_n;
   logic xfer_err_n, brk_req_n, translate_ctl_n, irq_pending_n, debug_ack_n;
   logic [31:0] paddr, pwdata, global_stat_in, rdata, prdata, xfer_addr, data_in, data_out;
   logic [31:0] global_ctl_out, v, last;
   logic clk_stop;
   logic [6:0] irq_vector_num, ev;
   logic [3:0] dly, core_status_code;
   logic [1:0] xfer_size, low_power_mode_n;
   logic [32:0] e;
   logic [32:0] exp_q[$];
   int fail_count, comparisons, cyc, i;
   css_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .xfer_req_n, .xfer_busy_n, .xfer_abort_n, .xfer_addr, .xfer_read, .xfer_size,
      .data_as_next_addr, .sequential_hint_n, .data_in, .data_out, .data_oe, .xfer_ack_n,
      .xfer_err_n, .brk_req_n, .translate_ctl_n, .soft_rst_n, .irq_n, .fast_irq_n,
      .auto_vector_n, .irq_vector_num, .irq_pending_n, .low_power_mode_n, .core_status_code,
      .global_ctl_out, .global_stat_in, .debug_req_n, .debug_ack_n);
   css_slave u_slv (.pclk, .presetn, .xfer_req_n, .xfer_abort_n, .xfer_read, .err_mode,
      .brk_mode, .dly, .rdata, .xfer_ack_n, .xfer_err_n, .brk_req_n, .data_in);
   // free-running clock; clk_stop holds it high the way power logic gates it
   always #5 pclk = clk_stop ? 1'b1 : ~pclk;
   task give_verdict;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; an idle cycle first keeps drivers single per step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      if (!w) exp_q.push_back(x);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task rd(input logic [7:0] a, input logic [32:0] x);
      apb(1'b0, a, 32'h0, x);
   endtask
   // launch one access and check pins, status and data
   task xfer(input logic r, input logic [1:0] sz, input logic ab, input logic em, input logic bm,
      input logic fa);
      logic [31:0] a, wd;
      logic [2:0] f;
      logic bp;
      a = $urandom;
      wd = $urandom;
      f = $urandom;
      bp = bm & (!f[1] | !f[0]);
      err_mode <= em;
      brk_mode <= bm;
      dly <= $urandom % 4;
      rdata <= $urandom;
      wr(8'h04, a);
      wr(8'h08, wd);
      wr(8'h0C, {23'h0, fa, ab, f[0], f[1], f[2], sz, r, 1'b1});
      @(posedge pclk);
      `CHK({xfer_req_n, xfer_read, xfer_size}, {1'b0, r, sz})
      `CHK({data_as_next_addr, xfer_addr}, {f[2], fa ? last : a})
      @(posedge pclk);
      `CHK({xfer_abort_n, xfer_busy_n, data_oe}, {!ab, 1'b0, !r && !ab})
      repeat (30) if (xfer_busy_n !== 1'b1) @(posedge pclk);
      rd(8'h10, {30'h0, bp, em, 1'b1});
      wr(8'h10, 32'h3F);
      if (r && !ab && !em) begin
         rd(8'h14, {1'b0, rdata});
         last = rdata;
      end
      if (!r) `CHK(data_out, wd)
   endtask
   // read results are compared here as they complete
   always @(posedge pclk) begin
      cyc++;
      if (psel && penable && !pwrite && pready === 1'b1) begin
         e = exp_q.pop_front();
         `CHK({pslverr, prdata}, e)
      end
      if (cyc == 20000) begin
         fail_count++;
         give_verdict;
      end
   end
   initial begin
      {pclk, clk_stop, presetn, psel, penable, pwrite, err_mode, brk_mode} = 8'h0;
      {soft_rst_n, irq_n, fast_irq_n, auto_vector_n, debug_req_n} = 5'h1F;
      {paddr, pwdata, global_stat_in, rdata, irq_vector_num, dly, last} = 0;
      void'($urandom(32'h0913));
      tick(12);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK({xfer_req_n, xfer_busy_n, xfer_abort_n, irq_pending_n}, 4'hF)
      `CHK({debug_ack_n, translate_ctl_n, low_power_mode_n}, 4'hF)
      rd(8'h00, 33'h0);
      v = $urandom;
      wr(8'h28, v);
      rd(8'h28, {1'b0, v});
      `CHK(global_ctl_out, v)
      v = $urandom;
      global_stat_in <= v;
      tick(4);
      wr(8'h2C, ~v);
      rd(8'h2C, {1'b0, v});
      rd(8'h40, {1'b1, 32'h0});
      wr(8'h00, 32'h1);
      @(posedge pclk);
      `CHK(translate_ctl_n, 1'b0)
      wr(8'h00, 32'h6);
      for (i = 0; i < 8; i++) xfer(i[0], 2'(i % 3), i == 7, i == 5, i == 3 || i == 6, i == 4);
      wr(8'h0C, 32'hD);
      rd(8'h10, {1'b0, 32'h8});
      wr(8'h10, 32'h3F);
      for (i = 0; i < 4; i++) begin
         v = $urandom;
         irq_vector_num <= v[6:0];
         auto_vector_n <= !i[1];
         if (i[0]) fast_irq_n <= 1'b0; else irq_n <= 1'b0;
         ev = i[1] ? (i[0] ? 7'h1C : 7'h18) : v[6:0];
         tick(5);
         `CHK(irq_pending_n, 1'b0)
         rd(8'h18, {18'h0, ev, 6'h0, i[0], 1'b1});
         {irq_n, fast_irq_n, auto_vector_n} <= 3'h7;
         tick(5);
         `CHK(irq_pending_n, 1'b1)
      end
      wr(8'h00, 32'h0);
      irq_n <= 1'b0;
      tick(5);
      `CHK(irq_pending_n, 1'b1)
      irq_n <= 1'b1;
      wr(8'h00, 32'h6);
      for (i = 0; i < 3; i++) begin
         wr(8'h1C, i);
         tick(4);
         `CHK({low_power_mode_n, core_status_code}, {i[1:0], 4'h4})
         // stop mode: gate the clock high, then restart it; state must survive
         if (i == 0) begin
            clk_stop = 1'b1;
            #100;
            `CHK({pclk, low_power_mode_n}, 3'h4)
            clk_stop = 1'b0;
         end
         if (i < 2) irq_n <= 1'b0; else debug_req_n <= 1'b0;
         tick(8);
         `CHK(low_power_mode_n, 2'h3)
         irq_n <= 1'b1;
         tick(5);
      end
      `CHK({debug_ack_n, core_status_code}, {1'b0, 4'h6})
      debug_req_n <= 1'b1;
      tick(4);
      `CHK(debug_ack_n, 1'b0)
      wr(8'h24, 32'h1);
      tick(2);
      `CHK(debug_ack_n, 1'b1)
      for (i = 8; i < 16; i++) begin
         wr(8'h20, i);
         tick(2);
         `CHK(core_status_code, (i == 14) ? 4'h0 : 4'(i))
      end
      soft_rst_n <= 1'b0;
      tick(5);
      `CHK(core_status_code, 4'h2)
      tick(1);
      soft_rst_n <= 1'b1;
      rd(8'h30, {1'b0, 32'h24});
      rd(8'h10, {1'b0, 32'h10});
      give_verdict;
   end
endmodule
